// >>> verilog/ipt_exc_regs.svh
`ifndef IPT_EXC_REGS_SVH
`define IPT_EXC_REGS_SVH

// ----------------------------------------
// Status word fields
// ----------------------------------------
`define IPT_TRACE_MODE_HIGH_BIT 15
`define IPT_TRACE_MODE_LOW_BIT 14
`define IPT_SUPERVISOR_BIT 13

// ----------------------------------------
// Vector numbers
// ----------------------------------------
`define IPT_VEC_ILLEGAL 8'h04
`define IPT_VEC_PRIVILEGE 8'h08
`define IPT_VEC_TRACE 8'h09
`define IPT_VEC_ALINE 8'h0A
`define IPT_VEC_FLINE 8'h0B

// ----------------------------------------
// Opcode patterns
// ----------------------------------------
`define IPT_NIBBLE_ALINE 4'hA
`define IPT_NIBBLE_FLINE 4'hF
`define IPT_OP_ALWAYS_ILLEGAL 16'h4AFC
`define IPT_OP_AND_IMM_SW 16'h027C
`define IPT_OP_EOR_IMM_SW 16'h0A7C
`define IPT_OP_OR_IMM_SW 16'h007C
`define IPT_OP_MOVE_FROM_SW 16'h40C0
`define IPT_OP_MOVE_TO_SW 16'h46C0
`define IPT_OP_STACK_PTR_MOVE 16'h4E60
`define IPT_OP_CTRL_REG_MOVE 16'h4E7A
`define IPT_OP_ALT_SPACE_MOVE 16'h0E00
`define IPT_OP_RESET 16'h4E70
`define IPT_OP_HALT_STOP 16'h4E72
`define IPT_OP_EXC_RETURN 16'h4E73
`define IPT_OP_LOW_POWER_HALT 16'hF800
`define IPT_EXT_LOW_POWER_HALT 16'h01C0
`define IPT_MASK_EA 16'hFFC0
`define IPT_MASK_REG 16'hFFF0
`define IPT_MASK_DIR 16'hFFFE
`define IPT_MASK_HI 16'hFF00

// ----------------------------------------
// Control register selectors
// ----------------------------------------
`define IPT_SEL_SRC_FC 12'h000
`define IPT_SEL_DST_FC 12'h001
`define IPT_SEL_USER_SP 12'h800
`define IPT_SEL_VEC_BASE 12'h801

// ----------------------------------------
// Register map
// ----------------------------------------
`define IPT_ADDR_VEC_BASE 8'h00
`define IPT_ADDR_STATUS 8'h04
`define IPT_VEC_BASE_RESET 32'h0000_0000

`endif

// >>> verilog/ipt_exc_pkg.sv
package ipt_exc_pkg;

	typedef enum logic [1:0] {
		IPT_TM_OFF = 2'b00,
		IPT_TM_FLOW = 2'b01,
		IPT_TM_ALL = 2'b10,
		IPT_TM_RSVD = 2'b11
	} ipt_trace_mode_t;

	typedef enum logic [0:0] {
		IPT_ST_IDLE = 1'b0,
		IPT_ST_REQ = 1'b1
	} ipt_state_t;

	typedef enum logic [1:0] {
		IPT_EXT_NONE = 2'b00,
		IPT_EXT_CTRL_SEL = 2'b01,
		IPT_EXT_INDEX = 2'b10,
		IPT_EXT_FLINE = 2'b11
	} ipt_ext_kind_t;

	typedef struct packed {
		logic valid;
		logic opcode_known;
		logic [15:0] word;
		ipt_ext_kind_t ext_kind;
		logic [15:0] ext_word;
		logic [31:0] pc;
	} ipt_dec_t;

	typedef struct packed {
		logic valid;
		logic flow_change;
		logic forced;
		logic forced_done;
		logic halt_instr;
		logic bus_fault;
		logic return_from_fault;
		logic [31:0] next_pc;
	} ipt_done_t;

	typedef struct packed {
		logic [7:0] vector;
		logic [31:0] vec_addr;
		logic [15:0] saved_psw;
		logic [15:0] new_psw;
		logic [31:0] frame_pc;
		logic [31:0] instr_addr;
	} ipt_frame_t;

endpackage

// >>> verilog/ipt_exc_unit.sv
`timescale 1ns/100ps
`include "ipt_exc_regs.svh"

module ipt_exc_unit
	import ipt_exc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [15:0] processor_status_word,
	input wire ipt_dec_t dec_i,
	input wire ipt_done_t done_i,
	input wire logic exc_ack,
	output logic exc_req_q,
	output ipt_frame_t exc_frame_q,
	output logic boundary_free_q,
	output logic stop_suppress_q,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic ipt_is_privileged(input logic [15:0] w);
		ipt_is_privileged = (w == `IPT_OP_AND_IMM_SW) || (w == `IPT_OP_EOR_IMM_SW)
			|| (w == `IPT_OP_OR_IMM_SW)
			|| ((w & `IPT_MASK_EA) == `IPT_OP_MOVE_FROM_SW)
			|| ((w & `IPT_MASK_EA) == `IPT_OP_MOVE_TO_SW)
			|| ((w & `IPT_MASK_REG) == `IPT_OP_STACK_PTR_MOVE)
			|| ((w & `IPT_MASK_DIR) == `IPT_OP_CTRL_REG_MOVE)
			|| (((w & `IPT_MASK_HI) == `IPT_OP_ALT_SPACE_MOVE) && (w[7:6] != 2'b11))
			|| (w == `IPT_OP_RESET) || (w == `IPT_OP_HALT_STOP)
			|| (w == `IPT_OP_EXC_RETURN) || (w == `IPT_OP_LOW_POWER_HALT);
	endfunction

	function automatic logic ipt_sel_valid(input logic [11:0] s);
		ipt_sel_valid = (s == `IPT_SEL_SRC_FC) || (s == `IPT_SEL_DST_FC)
			|| (s == `IPT_SEL_USER_SP) || (s == `IPT_SEL_VEC_BASE);
	endfunction

	function automatic logic [15:0] ipt_enter_super(input logic [15:0] w);
		logic [15:0] r;
		r = w;
		r[`IPT_SUPERVISOR_BIT] = 1'b1;
		r[`IPT_TRACE_MODE_HIGH_BIT] = 1'b0;
		r[`IPT_TRACE_MODE_LOW_BIT] = 1'b0;
		ipt_enter_super = r;
	endfunction

	// ----------------------------------------
	// Internal state
	// ----------------------------------------
	ipt_state_t st_q, st_d;
	logic trace_pend_q, trace_pend_d;
	logic wait_forced_q;
	logic defer_q;
	ipt_trace_mode_t mode_q, defer_mode_q, eff_mode;
	logic [31:0] instr_pc_q, defer_pc_q, trace_addr_q, trace_next_q;
	logic [31:0] vbr_q;
	logic [7:0] last_vec_q;
	logic accept, done_ev, trace_now, issue_dec, issue_trace;
	logic dec_hit;
	logic [7:0] dec_vec;
	logic [15:0] cur_psw;
	logic apb_acc, apb_hit;
	logic [31:0] apb_rd;

	assign cur_psw = processor_status_word;
	// The core starts an instruction only while the boundary is free
	assign accept = clk_en && dec_i.valid && boundary_free_q;
	assign done_ev = clk_en && done_i.valid;
	assign eff_mode = defer_q ? defer_mode_q : mode_q;
	// Reserved mode 11 traces nothing
	assign trace_now = !done_i.return_from_fault
		&& ((eff_mode == IPT_TM_ALL) || ((eff_mode == IPT_TM_FLOW) && done_i.flow_change));
	assign issue_dec = accept && dec_hit;
	assign issue_trace = clk_en && (st_q == IPT_ST_IDLE) && trace_pend_q && !wait_forced_q;

	// ----------------------------------------
	// Instruction screening
	// ----------------------------------------
	always_comb begin
		dec_hit = 1'b1;
		dec_vec = `IPT_VEC_ILLEGAL;
		if (dec_i.word[15:12] == `IPT_NIBBLE_ALINE) begin
			dec_vec = `IPT_VEC_ALINE;
		end else if ((dec_i.word[15:12] == `IPT_NIBBLE_FLINE)
			&& !((dec_i.word == `IPT_OP_LOW_POWER_HALT) && (dec_i.ext_kind == IPT_EXT_FLINE)
			&& (dec_i.ext_word == `IPT_EXT_LOW_POWER_HALT))) begin
			dec_vec = `IPT_VEC_FLINE;
		end else if ((dec_i.word == `IPT_OP_ALWAYS_ILLEGAL) || !dec_i.opcode_known
			|| ((dec_i.ext_kind == IPT_EXT_CTRL_SEL) && !ipt_sel_valid(dec_i.ext_word[11:0]))
			|| ((dec_i.ext_kind == IPT_EXT_INDEX) && dec_i.ext_word[8]
			&& ((dec_i.ext_word[5:4] == 2'b00) || (dec_i.ext_word[3:0] != 4'h0)))) begin
			dec_vec = `IPT_VEC_ILLEGAL;
		end else if (!cur_psw[`IPT_SUPERVISOR_BIT] && ipt_is_privileged(dec_i.word)) begin
			dec_vec = `IPT_VEC_PRIVILEGE;
		end else begin
			dec_hit = 1'b0;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		trace_pend_d = trace_pend_q;
		if (clk_en) begin
			unique case (st_q)
				IPT_ST_IDLE: begin
					if (issue_dec) begin
						st_d = IPT_ST_REQ;
					end else if (issue_trace) begin
						st_d = IPT_ST_REQ;
						trace_pend_d = 1'b0;
					end
				end
				IPT_ST_REQ: begin
					if (exc_ack) begin
						st_d = IPT_ST_IDLE;
					end
				end
			endcase
			// A pending trace closes the boundary to interrupts and breakpoints
			if (done_ev && trace_now) begin
				trace_pend_d = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= IPT_ST_IDLE;
			trace_pend_q <= 1'b0;
			boundary_free_q <= 1'b0;
			exc_req_q <= 1'b0;
		end else if (clk_en) begin
			st_q <= st_d;
			trace_pend_q <= trace_pend_d;
			boundary_free_q <= (st_d == IPT_ST_IDLE) && !trace_pend_d;
			exc_req_q <= (st_d == IPT_ST_REQ);
		end
	end

	// Forced exception of the traced instruction goes first; the set wins a clash
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_forced_q <= 1'b0;
		end else if (done_ev && trace_now) begin
			wait_forced_q <= done_i.forced;
		end else if (clk_en && done_i.forced_done) begin
			wait_forced_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Trace mode capture and fault deferral
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= IPT_TM_OFF;
			instr_pc_q <= 32'h0000_0000;
		end else if (accept) begin
			// Sampled at instruction start, not at completion
			mode_q <= ipt_trace_mode_t'({cur_psw[`IPT_TRACE_MODE_HIGH_BIT], cur_psw[`IPT_TRACE_MODE_LOW_BIT]});
			instr_pc_q <= dec_i.pc;
		end
	end

	// A faulted instruction keeps its trace until the restart ends normally
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			defer_q <= 1'b0;
			defer_mode_q <= IPT_TM_OFF;
			defer_pc_q <= 32'h0000_0000;
		end else if (clk_en && done_i.bus_fault && !defer_q) begin
			defer_q <= 1'b1;
			defer_mode_q <= mode_q;
			defer_pc_q <= instr_pc_q;
		end else if (done_ev && !done_i.return_from_fault) begin
			defer_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			trace_addr_q <= 32'h0000_0000;
			trace_next_q <= 32'h0000_0000;
		end else if (done_ev && trace_now) begin
			trace_addr_q <= defer_q ? defer_pc_q : instr_pc_q;
			trace_next_q <= done_i.next_pc;
		end
	end

	// Halt with instruction trace: the core loads status, then takes trace, never stops
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stop_suppress_q <= 1'b0;
		end else if (clk_en) begin
			stop_suppress_q <= done_ev && done_i.halt_instr && eff_mode[1];
		end
	end

	// ----------------------------------------
	// Exception frame
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			exc_frame_q <= '0;
			last_vec_q <= 8'h00;
		end else if (clk_en && (st_q == IPT_ST_IDLE)) begin
			if (issue_dec) begin
				// Taken before any register changes; nothing of the instruction runs
				exc_frame_q.vector <= dec_vec;
				exc_frame_q.vec_addr <= vbr_q + {22'h000000, dec_vec, 2'b00};
				exc_frame_q.saved_psw <= cur_psw;
				exc_frame_q.new_psw <= ipt_enter_super(cur_psw);
				exc_frame_q.frame_pc <= dec_i.pc;
				exc_frame_q.instr_addr <= dec_i.pc;
				last_vec_q <= dec_vec;
			end else if (issue_trace) begin
				exc_frame_q.vector <= `IPT_VEC_TRACE;
				exc_frame_q.vec_addr <= vbr_q + {22'h000000, `IPT_VEC_TRACE, 2'b00};
				exc_frame_q.saved_psw <= cur_psw;
				exc_frame_q.new_psw <= ipt_enter_super(cur_psw);
				exc_frame_q.frame_pc <= trace_next_q;
				exc_frame_q.instr_addr <= trace_addr_q;
				last_vec_q <= `IPT_VEC_TRACE;
			end
		end
	end

	// ----------------------------------------
	// APB slave, one wait state per access
	// ----------------------------------------
	assign apb_acc = psel && penable;
	always_comb begin
		apb_hit = 1'b1;
		apb_rd = 32'h0000_0000;
		unique case (paddr)
			`IPT_ADDR_VEC_BASE: apb_rd = vbr_q;
			`IPT_ADDR_STATUS: begin
				apb_rd = {16'h0000, defer_q, wait_forced_q, trace_pend_q, 4'h0, st_q == IPT_ST_REQ, last_vec_q};
				apb_hit = !pwrite;
			end
			default: apb_hit = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (clk_en) begin
			pready <= apb_acc && !pready;
			pslverr <= apb_acc && !pready && !apb_hit;
			if (apb_acc && !pready) begin
				prdata <= pwrite ? 32'h0000_0000 : apb_rd;
			end
		end
	end

	// Vector base steers every vector fetch
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			vbr_q <= `IPT_VEC_BASE_RESET;
		end else if (clk_en && apb_acc && pready && pwrite && (paddr == `IPT_ADDR_VEC_BASE)) begin
			vbr_q <= pwdata;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	vector_fetch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(exc_req_q) && !$past(apb_acc && pready && pwrite)
		|-> exc_frame_q.vec_addr == vbr_q + {22'h000000, exc_frame_q.vector, 2'b00})
		else $error("vector fetch address wrong");

	aline_vector_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		accept && (dec_i.word[15:12] == 4'hA) |=> exc_req_q && (exc_frame_q.vector == 8'h0A))
		else $error("A-pattern word not sent to vector 10");

	fline_vector_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		accept && (dec_i.word[15:12] == 4'hF) && (dec_i.ext_kind != IPT_EXT_FLINE)
		|=> exc_req_q && (exc_frame_q.vector == 8'h0B))
		else $error("F-pattern word not sent to vector 11");

	always_illegal_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		accept && (dec_i.word == 16'h4AFC)
		|=> exc_req_q && (exc_frame_q.vector == 8'h04) && (exc_frame_q.frame_pc == $past(dec_i.pc)))
		else $error("4AFC not illegal");

	user_privilege_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		accept && dec_i.opcode_known && !cur_psw[13] && (dec_i.word == 16'h4E73)
		|=> exc_req_q && (exc_frame_q.vector == 8'h08))
		else $error("user return-from-exception not privileged");

	super_entry_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		exc_req_q |-> exc_frame_q.new_psw[13] && (exc_frame_q.new_psw[15:14] == 2'b00)
		&& (exc_frame_q.new_psw[12:0] == exc_frame_q.saved_psw[12:0]))
		else $error("exception entry status word wrong");

	trace_blocks_boundary_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		trace_pend_q |-> !boundary_free_q)
		else $error("boundary opened while trace pending");

	flow_untaken_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		done_ev && !defer_q && (mode_q == IPT_TM_FLOW) && !done_i.flow_change && !trace_pend_q
		|=> !trace_pend_q)
		else $error("flow mode traced a sequential instruction");

	fault_return_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		done_ev && done_i.return_from_fault && !trace_pend_q |=> !trace_pend_q)
		else $error("fault-resuming return was traced");

	halt_trace_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		done_ev && done_i.halt_instr && (mode_q == IPT_TM_ALL) && !defer_q
		|=> stop_suppress_q && trace_pend_q)
		else $error("traced halt was allowed to stop");

	trace_frame_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		issue_trace |=> exc_req_q && (exc_frame_q.vector == 8'h09)
		&& (exc_frame_q.frame_pc == $past(trace_next_q)))
		else $error("trace frame wrong");

	deferred_trace_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		done_ev && defer_q && !done_i.return_from_fault && (defer_mode_q == IPT_TM_ALL)
		|=> trace_pend_q && (trace_addr_q == $past(defer_pc_q)))
		else $error("deferred trace lost after restart");

	fault_no_trace_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && done_i.bus_fault && !done_i.valid && !trace_pend_q |=> !trace_pend_q)
		else $error("aborted instruction was traced");

	aline_cover_c: cover property (@(posedge ref_clk) accept && (dec_i.word[15:12] == 4'hA));
	halt_trace_c: cover property (@(posedge ref_clk) stop_suppress_q);
	trace_taken_c: cover property (@(posedge ref_clk) issue_trace);
	forced_first_c: cover property (@(posedge ref_clk) wait_forced_q ##1 !wait_forced_q);
	deferred_c: cover property (@(posedge ref_clk) defer_q && done_ev && trace_now);

endmodule // ipt_exc_unit

// >>> tb/ipt_exc_unit_tb.sv
`timescale 1ns/100ps
`include "ipt_exc_regs.svh"

module ipt_exc_unit_tb
	import ipt_exc_pkg::*;
;

	localparam logic [15:0] PRIV[12] = '{`IPT_OP_AND_IMM_SW, `IPT_OP_EOR_IMM_SW, `IPT_OP_OR_IMM_SW,
		`IPT_OP_MOVE_FROM_SW, `IPT_OP_MOVE_TO_SW, `IPT_OP_STACK_PTR_MOVE, `IPT_OP_ALT_SPACE_MOVE,
		`IPT_OP_RESET, `IPT_OP_HALT_STOP, `IPT_OP_EXC_RETURN, `IPT_OP_CTRL_REG_MOVE, `IPT_OP_LOW_POWER_HALT};

	logic ref_clk, rst_n, clk_en, exc_ack, psel, penable, pwrite, pready, pslverr;
	logic exc_req_q, boundary_free_q, stop_suppress_q, seen_stop;
	logic [15:0] psw;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, vbr;
	ipt_dec_t dec;
	ipt_done_t dn;
	ipt_frame_t exc_frame_q;
	int failures, checks;

	ipt_exc_unit DUT (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .processor_status_word(psw),
		.dec_i(dec), .done_i(dn), .exc_ack(exc_ack), .exc_req_q(exc_req_q), .exc_frame_q(exc_frame_q),
		.boundary_free_q(boundary_free_q), .stop_suppress_q(stop_suppress_q), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// Other outputs are looked at on the falling edge; bus answers are taken at the rising edge with pready high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic err);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1 && n++ < 20) @(posedge ref_clk);
		chk(pready, 1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic issue(input logic [15:0] w, input ipt_ext_kind_t k, input logic [15:0] e, input logic kn,
		input logic [15:0] p, input logic [31:0] pc);
		int n;
		n = 0;
		@(negedge ref_clk);
		while (boundary_free_q !== 1'b1 && n++ < 50) @(negedge ref_clk);
		@(posedge ref_clk);
		psw <= p;
		@(posedge ref_clk);
		dec <= '{1'b1, kn, w, k, e, pc};
		@(posedge ref_clk);
		dec.valid <= 1'b0;
	endtask

	task automatic fin(input logic fl, input logic fo, input logic hl, input logic bf, input logic rf,
		input logic [31:0] npc);
		@(posedge ref_clk);
		dn <= '{!bf, fl, fo, 1'b0, hl, bf, rf, npc};
		@(posedge ref_clk);
		dn <= '0;
	endtask

	task automatic quiet(input int n, output logic s);
		s = 1'b0;
		repeat (n) begin
			@(negedge ref_clk);
			if (exc_req_q !== 1'b0) s = 1'b1;
		end
	endtask

	task automatic take(input logic [7:0] v, input logic [15:0] p, input logic [31:0] pc, input logic [31:0] ia);
		int n;
		n = 0;
		@(negedge ref_clk);
		while (exc_req_q !== 1'b1 && n++ < 10) @(negedge ref_clk);
		chk(exc_req_q, 1);
		chk(exc_frame_q.vector, v);
		chk(exc_frame_q.vec_addr, vbr + {v, 2'b00});
		chk(exc_frame_q.saved_psw, p);
		chk(exc_frame_q.new_psw, (p | 16'h2000) & 16'h3FFF);
		chk(exc_frame_q.frame_pc, pc);
		if (v == `IPT_VEC_TRACE) chk(exc_frame_q.instr_addr, ia);
		@(posedge ref_clk);
		exc_ack <= 1'b1;
		@(posedge ref_clk);
		exc_ack <= 1'b0;
	endtask

	// Trace bits set in p check that a refused instruction leaves no trace behind
	task automatic dexc(input logic [15:0] w, input ipt_ext_kind_t k, input logic [15:0] e, input logic kn,
		input logic [15:0] p, input logic [7:0] v);
		logic s;
		issue(w, k, e, kn, p, 32'h0000_0200);
		take(v, p, 32'h0000_0200, 0);
		quiet(6, s);
		chk(s, 0);
	endtask

	task automatic nox(input logic [15:0] w, input ipt_ext_kind_t k, input logic [15:0] e, input logic [15:0] p);
		logic s;
		issue(w, k, e, 1'b1, p, 32'h0000_0400);
		quiet(4, s);
		chk(s, 0);
		fin(0, 0, 0, 0, 0, 32'h0000_0402);
	endtask

	task automatic trc(input logic [15:0] p, input logic fl, input logic hl, input logic ex);
		logic s;
		issue(16'h4E71, IPT_EXT_NONE, 0, 1'b1, p, 32'h0000_0300);
		fin(fl, 0, hl, 0, 0, 32'h0000_0302);
		if (ex) begin
			@(negedge ref_clk);
			chk(boundary_free_q, 0);
			take(`IPT_VEC_TRACE, p, 32'h0000_0302, 32'h0000_0300);
		end else begin
			quiet(6, s);
			chk(s, 0);
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_apb;
		logic [31:0] r;
		logic e;
		apb(0, `IPT_ADDR_VEC_BASE, 0, r, e);
		chk(r, `IPT_VEC_BASE_RESET);
		apb(1, `IPT_ADDR_VEC_BASE, vbr, r, e);
		chk(e, 0);
		apb(0, `IPT_ADDR_VEC_BASE, 0, r, e);
		chk(r, vbr);
		apb(0, 8'h08, 0, r, e);
		chk(e, 1);
		apb(1, `IPT_ADDR_STATUS, 32'hFFFF_FFFF, r, e);
		chk(e, 1);
		$display("test apb done");
	endtask

	task automatic t_dec;
		ipt_ext_kind_t k;
		dexc(16'hA123, IPT_EXT_NONE, 0, 0, 16'h8000, `IPT_VEC_ALINE);
		dexc(16'hF200, IPT_EXT_NONE, 0, 0, 16'h0000, `IPT_VEC_FLINE);
		dexc(`IPT_OP_LOW_POWER_HALT, IPT_EXT_FLINE, 16'h0123, 1, 16'h2000, `IPT_VEC_FLINE);
		dexc(`IPT_OP_ALWAYS_ILLEGAL, IPT_EXT_NONE, 0, 1, 16'h4000, `IPT_VEC_ILLEGAL);
		dexc(16'h4E7F, IPT_EXT_NONE, 0, 0, 16'h2000, `IPT_VEC_ILLEGAL);
		dexc(`IPT_OP_CTRL_REG_MOVE, IPT_EXT_CTRL_SEL, 16'h0123, 1, 16'h2000, `IPT_VEC_ILLEGAL);
		dexc(16'h3030, IPT_EXT_INDEX, 16'h0111, 1, 16'h2000, `IPT_VEC_ILLEGAL);
		dexc(16'h3030, IPT_EXT_INDEX, 16'h0100, 1, 16'h2000, `IPT_VEC_ILLEGAL);
		nox(16'h3030, IPT_EXT_INDEX, 16'h0110, 16'h2000);
		for (int i = 0; i < 12; i++) begin
			k = (i == 10) ? IPT_EXT_CTRL_SEL : (i == 11) ? IPT_EXT_FLINE : IPT_EXT_NONE;
			dexc(PRIV[i], k, (i == 10) ? `IPT_SEL_VEC_BASE : `IPT_EXT_LOW_POWER_HALT, 1, 16'h0000,
				`IPT_VEC_PRIVILEGE);
			nox(PRIV[i], k, (i == 10) ? `IPT_SEL_VEC_BASE : `IPT_EXT_LOW_POWER_HALT, 16'h2000);
		end
		$display("test decode done");
	endtask

	task automatic t_trace;
		logic s;
		logic [31:0] r;
		logic e;
		trc(16'h0000, 1, 0, 0);
		trc(16'h4000, 0, 0, 0);
		trc(16'h4000, 1, 0, 1);
		trc(16'h8000, 0, 0, 1);
		trc(16'hC000, 1, 0, 0);
		seen_stop = 1'b0;
		trc(16'hA000, 0, 1, 1);
		chk(seen_stop, 1);
		issue(16'h4E71, IPT_EXT_NONE, 0, 1'b1, 16'h8000, 32'h0000_0300);
		fin(0, 1, 0, 0, 0, 32'h0000_0302);
		quiet(4, s);
		chk(s, 0);
		@(posedge ref_clk);
		dn.forced_done <= 1'b1;
		@(posedge ref_clk);
		dn <= '0;
		take(`IPT_VEC_TRACE, 16'h8000, 32'h0000_0302, 32'h0000_0300);
		issue(16'h4E71, IPT_EXT_NONE, 0, 1'b1, 16'h8000, 32'h0000_0300);
		fin(0, 0, 0, 1, 0, 0);
		quiet(6, s);
		chk(s, 0);
		apb(0, `IPT_ADDR_STATUS, 0, r, e);
		chk(r, {16'h0000, 8'h80, `IPT_VEC_TRACE});
		issue(`IPT_OP_EXC_RETURN, IPT_EXT_NONE, 0, 1'b1, 16'hA000, 32'h0000_0500);
		fin(1, 0, 0, 0, 1, 32'h0000_0300);
		quiet(6, s);
		chk(s, 0);
		trc(16'h8000, 0, 0, 1);
		$display("test trace done");
	endtask

	// An acknowledge while frozen must be lost; request and frame stand until taken
	task automatic t_freeze;
		issue(16'hA000, IPT_EXT_NONE, 0, 0, 16'h2000, 32'h0000_0600);
		@(posedge ref_clk);
		clk_en <= 1'b0;
		exc_ack <= 1'b1;
		@(posedge ref_clk);
		exc_ack <= 1'b0;
		@(negedge ref_clk);
		chk(exc_req_q, 1);
		@(posedge ref_clk);
		clk_en <= 1'b1;
		take(`IPT_VEC_ALINE, 16'h2000, 32'h0000_0600, 0);
		$display("test freeze done");
	endtask

	// ----------------------------------------
	// Clock, reset, run
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	always @(negedge ref_clk) if (stop_suppress_q === 1'b1) seen_stop = 1'b1;

	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		exc_ack = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		psw = 16'h2000;
		dec = '0;
		dn = '0;
		seen_stop = 1'b0;
		vbr = 32'h0000_4000;
		failures = 0;
		checks = 0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_apb;
		t_dec;
		t_trace;
		t_freeze;
		complete_run;
	end

	// The whole run needs a few hundred cycles; the margin covers slow answers
	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		$display("Error at %0t: watchdog expired", $time);
		complete_run;
	end

endmodule // ipt_exc_unit_tb
